// [core/ocg_regs.vh]
// register offsets, fields, reset values and timing counts of the clock generator
`ifndef OCG_REGS_VH
`define OCG_REGS_VH
`define OCG_ADDR_W 20
`define OCG_FREQ_SEL_ADDR 20'hF00A8
`define OCG_SPEED_MODE_ADDR 20'hF00F3
`define OCG_SPEED_MODE_RESET 8'h00
`define OCG_SUPPLY_BIT 4
`define OCG_CODE_W 3
`define OCG_CODE_20M 3'h1
`define OCG_CODE_10M 3'h2
`define OCG_CODE_5M 3'h3
`define OCG_CODE_2M5 3'h4
`define OCG_CODE_1M25 3'h5
`define OCG_CODE_DEFAULT 3'h1
`define OCG_ACC_W 16
`define OCG_CORE_KHZ 250000
`define OCG_INC_20M (20000 * 65536 / (`OCG_CORE_KHZ / 2))
`define OCG_INC_10M (10000 * 65536 / (`OCG_CORE_KHZ / 2))
`define OCG_INC_5M (5000 * 65536 / (`OCG_CORE_KHZ / 2))
`define OCG_INC_2M5 (2500 * 65536 / (`OCG_CORE_KHZ / 2))
`define OCG_INC_1M25 (1250 * 65536 / (`OCG_CORE_KHZ / 2))
`define OCG_STAB_NS 1000
`define OCG_STAB_CYC ((`OCG_STAB_NS * 250 + 999) / 1000)
`define OCG_OLD_CLKS 3
`define OCG_NEW_CLKS 3
`define OCG_CNT_W 9
`endif

// [core/ocg_fast_osc.v]
// fast on-chip oscillator model: phase accumulator on the core clock
`timescale 1ns/10ps
`include "ocg_regs.vh"
module ocg_fast_osc (
  input wire core_clk,
  input wire rst_n,
  input wire run,
  input wire [2:0] code,
  output reg osc_clk_reg,
  output reg rise_tick_reg
);
  reg [`OCG_ACC_W-1:0] acc_reg;
  reg [31:0] inc32;
  wire [`OCG_ACC_W:0] sum;
  always @* begin
    case (code)
      `OCG_CODE_10M: inc32 = `OCG_INC_10M;
      `OCG_CODE_5M: inc32 = `OCG_INC_5M;
      `OCG_CODE_2M5: inc32 = `OCG_INC_2M5;
      `OCG_CODE_1M25: inc32 = `OCG_INC_1M25;
      default: inc32 = `OCG_INC_20M;
    endcase
  end
  assign sum = {1'b0, acc_reg} + {1'b0, inc32[`OCG_ACC_W-1:0]};
  always @(posedge core_clk) begin
    if (!rst_n || !run) begin
      acc_reg <= {`OCG_ACC_W{1'b0}};
      osc_clk_reg <= 1'b0;
      rise_tick_reg <= 1'b0;
    end else begin
      acc_reg <= sum[`OCG_ACC_W-1:0];
      rise_tick_reg <= sum[`OCG_ACC_W] & ~osc_clk_reg;
      if (sum[`OCG_ACC_W])
        osc_clk_reg <= ~osc_clk_reg;
    end
  end
endmodule // ocg_fast_osc

// [core/ocg_clock_gen.v]
// clock generator: fast/slow oscillator control, start-up, switching, standby
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "ocg_regs.vh"
module ocg_clock_gen (
  input wire core_clk,
  input wire rst_n,
  input wire por_detect,
  input wire [7:0] cfg_option_byte,
  input wire wdt_running,
  input wire halt_req,
  input wire stop_req,
  input wire wake_irq,
  input wire [19:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire fast_osc_clock,
  output reg fast_osc_run,
  output reg slow_osc_run,
  output reg main_system_clock_tick,
  output reg cpu_clock_tick,
  output reg cpu_reset_n,
  output reg halt_active,
  output reg stop_active,
  output reg switch_busy
);
  localparam [6:0] ST_POR = 7'h01;
  localparam [6:0] ST_STAB = 7'h02;
  localparam [6:0] ST_RUN = 7'h04;
  localparam [6:0] ST_SW_OLD = 7'h08;
  localparam [6:0] ST_SW_NEW = 7'h10;
  localparam [6:0] ST_HALT = 7'h20;
  localparam [6:0] ST_STOP = 7'h40;

  reg [6:0] state_reg;
  reg [6:0] state_next;
  reg [`OCG_CNT_W-1:0] cnt_reg;
  reg [`OCG_CNT_W-1:0] cnt_next;
  reg [2:0] freq_sel_reg;
  reg [2:0] active_code_reg;
  reg [2:0] active_code_next;
  // code latched at switch start; writes during a switch wait for the next one
  reg [2:0] target_code_reg;
  reg [2:0] target_code_next;
  reg [7:0] speed_mode_reg;
  reg por_meta_reg;
  reg por_sync_reg;
  reg osc_run_next;
  wire osc_tick;
  wire cfg_valid;
  wire wr_valid;
  wire [2:0] cfg_code;

  function is_valid_code;
    input [2:0] c;
    begin
      is_valid_code = (c >= `OCG_CODE_20M) && (c <= `OCG_CODE_1M25);
    end
  endfunction

  assign cfg_code = cfg_option_byte[2:0];
  assign cfg_valid = is_valid_code(cfg_code);
  assign wr_valid = is_valid_code(reg_wdata[2:0]);

  // power-on detect pin passes two flops
  always @(posedge core_clk) begin
    if (!rst_n) begin
      por_meta_reg <= 1'b0;
      por_sync_reg <= 1'b0;
    end else begin
      por_meta_reg <= por_detect;
      por_sync_reg <= por_meta_reg;
    end
  end

  ocg_fast_osc u_fast_osc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(fast_osc_run),
    .code(active_code_reg),
    .osc_clk_reg(fast_osc_clock),
    .rise_tick_reg(osc_tick)
  );

  // registers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      freq_sel_reg <= cfg_valid ? cfg_code : `OCG_CODE_DEFAULT;
      speed_mode_reg <= `OCG_SPEED_MODE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `OCG_FREQ_SEL_ADDR && wr_valid)
        freq_sel_reg <= reg_wdata[2:0];
      if (reg_addr == `OCG_SPEED_MODE_ADDR)
        speed_mode_reg <= reg_wdata & (8'h01 << `OCG_SUPPLY_BIT);
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == `OCG_FREQ_SEL_ADDR)
      reg_rdata <= {5'h00, freq_sel_reg};
    else if (reg_rd && reg_addr == `OCG_SPEED_MODE_ADDR)
      reg_rdata <= speed_mode_reg;
    else
      reg_rdata <= 8'h00;
  end

  // slow oscillator gate; its clock never reaches the CPU path
  always @(posedge core_clk) begin
    if (!rst_n)
      slow_osc_run <= 1'b0;
    else
      slow_osc_run <= wdt_running | speed_mode_reg[`OCG_SUPPLY_BIT];
  end

  // sequencer
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    active_code_next = active_code_reg;
    target_code_next = target_code_reg;
    osc_run_next = 1'b1;
    case (state_reg)
      ST_POR: begin
        osc_run_next = 1'b0;
        cnt_next = {`OCG_CNT_W{1'b0}};
        if (por_sync_reg) begin
          state_next = ST_STAB;
          osc_run_next = 1'b1;
        end
      end
      ST_STAB: begin
        if (cnt_reg == `OCG_STAB_CYC - 1) begin
          state_next = ST_RUN;
          cnt_next = {`OCG_CNT_W{1'b0}};
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_RUN: begin
        cnt_next = {`OCG_CNT_W{1'b0}};
        if (stop_req) begin
          state_next = ST_STOP;
          osc_run_next = 1'b0;
        end else if (halt_req) begin
          state_next = ST_HALT;
        end else if (freq_sel_reg != active_code_reg) begin
          state_next = ST_SW_OLD;
          target_code_next = freq_sel_reg;
        end
      end
      ST_SW_OLD: begin
        if (osc_tick) begin
          if (cnt_reg == `OCG_OLD_CLKS - 1) begin
            state_next = ST_SW_NEW;
            active_code_next = target_code_reg;
            cnt_next = {`OCG_CNT_W{1'b0}};
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      ST_SW_NEW: begin
        if (osc_tick) begin
          if (cnt_reg == `OCG_NEW_CLKS - 1) begin
            state_next = ST_RUN;
            cnt_next = {`OCG_CNT_W{1'b0}};
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      ST_HALT: begin
        if (wake_irq)
          state_next = ST_RUN;
      end
      ST_STOP: begin
        osc_run_next = 1'b0;
        cnt_next = {`OCG_CNT_W{1'b0}};
        // oscillator restarts one cycle later so it never overlaps stop_active
        if (wake_irq)
          state_next = ST_STAB;
      end
      default: begin
        state_next = ST_POR;
        osc_run_next = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_POR;
      cnt_reg <= {`OCG_CNT_W{1'b0}};
      active_code_reg <= cfg_valid ? cfg_code : `OCG_CODE_DEFAULT;
      target_code_reg <= cfg_valid ? cfg_code : `OCG_CODE_DEFAULT;
      fast_osc_run <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      active_code_reg <= active_code_next;
      target_code_reg <= target_code_next;
      fast_osc_run <= osc_run_next;
    end
  end

  // clock enables and status outputs
  always @(posedge core_clk) begin
    if (!rst_n) begin
      main_system_clock_tick <= 1'b0;
      cpu_clock_tick <= 1'b0;
      cpu_reset_n <= 1'b0;
      halt_active <= 1'b0;
      stop_active <= 1'b0;
      switch_busy <= 1'b0;
    end else begin
      // no tick on the edge that stops the oscillator
      main_system_clock_tick <= osc_tick & osc_run_next &
        ((state_reg == ST_RUN) || (state_reg == ST_SW_OLD) || (state_reg == ST_HALT));
      cpu_clock_tick <= osc_tick & osc_run_next &
        ((state_reg == ST_RUN) || (state_reg == ST_SW_OLD));
      if (state_reg == ST_RUN)
        cpu_reset_n <= 1'b1;
      halt_active <= (state_reg == ST_HALT);
      stop_active <= (state_reg == ST_STOP);
      switch_busy <= (state_reg == ST_SW_OLD) || (state_reg == ST_SW_NEW);
    end
  end
endmodule // ocg_clock_gen

// [bench/ocg_clock_gen_sva.sv]
// port assertions for the clock generator
`timescale 1ns/10ps
`include "ocg_regs.vh"
module ocg_clock_gen_sva (
  input wire core_clk,
  input wire rst_n,
  input wire por_detect,
  input wire wdt_running,
  input wire halt_req,
  input wire stop_req,
  input wire [19:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire fast_osc_run,
  input wire slow_osc_run,
  input wire cpu_clock_tick,
  input wire cpu_reset_n,
  input wire halt_active,
  input wire stop_active,
  input wire switch_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_halted; ##2 halt_active; endsequence
  sequence s_osc_up; ##[1:8] fast_osc_run; endsequence
  property p_slow_on; wdt_running |=> slow_osc_run; endproperty
  property p_slow_off; $fell(slow_osc_run) |-> !$past(wdt_running); endproperty
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_rd_hi;
    $past(reg_rd) && $past(reg_addr) == `OCG_FREQ_SEL_ADDR |-> reg_rdata[7:3] == 5'h00;
  endproperty
  property p_cpu_src; cpu_clock_tick |-> fast_osc_run && !stop_active; endproperty
  property p_stop; stop_active |-> !fast_osc_run; endproperty
  property p_halt; halt_active |-> !cpu_clock_tick; endproperty
  property p_halt_go;
    halt_req && !stop_req && cpu_reset_n && !switch_busy && !halt_active && !stop_active
      |-> s_halted;
  endproperty
  property p_osc_start; por_detect && !cpu_reset_n |-> s_osc_up; endproperty
  a_slow_on: assert property (p_slow_on) else $error("slow osc off");
  a_slow_off: assert property (p_slow_off) else $error("slow osc stop");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
  a_rd_hi: assert property (p_rd_hi) else $error("high bits set");
  a_cpu_src: assert property (p_cpu_src) else $error("cpu source");
  a_stop: assert property (p_stop) else $error("osc in stop");
  a_halt: assert property (p_halt) else $error("cpu in halt");
  a_halt_go: assert property (p_halt_go) else $error("halt late");
  a_osc_start: assert property (p_osc_start) else $error("osc start");
endmodule // ocg_clock_gen_sva
bind ocg_clock_gen ocg_clock_gen_sva ocg_clock_gen_sva_inst (.core_clk, .rst_n, .por_detect,
  .wdt_running, .halt_req, .stop_req, .reg_addr, .reg_rd, .reg_rdata, .fast_osc_run,
  .slow_osc_run, .cpu_clock_tick, .cpu_reset_n, .halt_active, .stop_active, .switch_busy);

// [bench/ocg_clock_gen_tb.sv]
// testbench for the clock generator
`timescale 1ns/10ps
`include "ocg_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t %h %h", $time, a, b); end end
`define WT(c, n) for (i = 0; !(c) && i < n; i++) begin @(posedge core_clk); #1; end
module ocg_clock_gen_tb;
  reg core_clk, rst_n = 0, por_detect = 0, wdt_running = 0, halt_req = 0;
  reg stop_req = 0, wake_irq = 0, reg_wr = 0, reg_rd = 0;
  reg [7:0] cfg_option_byte = 8'hFA, reg_wdata = 8'h00;
  reg [19:0] reg_addr = 20'h00000;
  wire [7:0] reg_rdata;
  wire fast_osc_clock, fast_osc_run, slow_osc_run, main_system_clock_tick, cpu_clock_tick;
  wire cpu_reset_n, halt_active, stop_active, switch_busy;
  int fails = 0, num_checks = 0, i, cur;
  localparam [19:0] FA = `OCG_FREQ_SEL_ADDR, SA = `OCG_SPEED_MODE_ADDR;
  ocg_clock_gen ocg_clock_gen_inst (.core_clk, .rst_n, .por_detect, .cfg_option_byte,
    .wdt_running, .halt_req, .stop_req, .wake_irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .fast_osc_clock, .fast_osc_run, .slow_osc_run, .main_system_clock_tick,
    .cpu_clock_tick, .cpu_reset_n, .halt_active, .stop_active, .switch_busy);
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  task wr(input [19:0] a, input [7:0] d);
    @(posedge core_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge core_clk); reg_wr <= 0;
  endtask
  task rd(input [19:0] a, input [7:0] e);
    @(posedge core_clk); reg_addr <= a; reg_rd <= 1;
    @(posedge core_clk); reg_rd <= 0;
    #1 `CHK(reg_rdata, e)
  endtask
  task pulse(input int k);
    @(posedge core_clk);
    if (k == 0) halt_req <= 1; else if (k == 1) stop_req <= 1; else wake_irq <= 1;
    @(posedge core_clk); {halt_req, stop_req, wake_irq} <= 3'h0;
  endtask
  task t_period(input [2:0] c);
    `WT(main_system_clock_tick, 400)
    `CHK(fast_osc_clock, 1'b1)
    @(posedge core_clk); #1;
    `WT(main_system_clock_tick, 400)
    `CHK(i + 1 >= (12 << (c - 1)) && i + 1 <= (14 << (c - 1)), 1'b1)
  endtask
  task t_reset(input [7:0] cfg, input [2:0] code);
    @(posedge core_clk); rst_n <= 0; por_detect <= 0; cfg_option_byte <= cfg;
    repeat (16) @(posedge core_clk);
    rst_n <= 1;
    repeat (10) @(posedge core_clk);
    #1 `CHK(cpu_reset_n | fast_osc_run, 1'b0)
    @(posedge core_clk); por_detect <= 1;
    `WT(cpu_reset_n, 600)
    `CHK(i >= 250 && i < 600, 1'b1)
    rd(FA, {5'h00, code});
    rd(SA, 8'h00);
    t_period(code);
    cur = code;
    $display("reset test done");
  endtask
  task t_freq(input [2:0] c);
    wr(FA, {5'h1F, c});
    `WT(switch_busy, 20)
    `CHK(switch_busy, 1'b1)
    `WT(!switch_busy, 3000)
    `CHK(i <= (42 << (cur - 1)) + (42 << (c - 1)) + 8, 1'b1)
    rd(FA, {5'h00, c});
    wr(FA, 8'h07);
    rd(FA, {5'h00, c});
    t_period(c);
    cur = c;
    $display("freq test done");
  endtask
  task t_slow;
    @(posedge core_clk); wdt_running <= 1;
    repeat (3) @(posedge core_clk);
    #1 `CHK(slow_osc_run, 1'b1)
    wr(SA, 8'hFF);
    rd(SA, 8'h10);
    @(posedge core_clk); wdt_running <= 0;
    repeat (3) @(posedge core_clk);
    #1 `CHK(slow_osc_run, 1'b1)
    wr(SA, 8'h00);
    repeat (3) @(posedge core_clk);
    #1 `CHK(slow_osc_run, 1'b0)
    wr(20'h00000, 8'hFF);
    rd(20'h00000, 8'h00);
    $display("slow osc test done");
  endtask
  task t_standby;
    pulse(0);
    repeat (2) @(posedge core_clk);
    #1 `CHK(halt_active, 1'b1)
    `WT(main_system_clock_tick, 400)
    `CHK(main_system_clock_tick, 1'b1)
    `CHK({cpu_clock_tick, fast_osc_clock}, 2'h1)
    pulse(2);
    repeat (3) @(posedge core_clk);
    #1 `CHK(halt_active, 1'b0)
    pulse(1);
    repeat (2) @(posedge core_clk);
    #1 `CHK({stop_active, fast_osc_run, fast_osc_clock}, 3'h4)
    pulse(2);
    `WT(cpu_clock_tick, 1000)
    `CHK({stop_active, cpu_clock_tick, fast_osc_run}, 3'h3)
    $display("standby test done");
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
  initial begin
    t_reset(8'hFA, 3'h2);
    for (int c = 1; c <= 5; c++) t_freq(c[2:0]);
    t_slow;
    t_standby;
    t_reset(8'hFC, 3'h4);
    t_reset(8'hFF, 3'h1);
    print_verdict;
  end
endmodule // ocg_clock_gen_tb
